// File: inc/pia_pkg.sv
`default_nettype none

package pia_pkg;

    // ----------------------------------------------------------------
    // management access
    // ----------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;

    localparam logic [ADDR_W-1:0] OFS_ID_HIGH = 5'h02;
    localparam logic [ADDR_W-1:0] OFS_ID_LOW = 5'h03;
    localparam logic [ADDR_W-1:0] OFS_ADVERT = 5'h04;

    // ----------------------------------------------------------------
    // identifier layout
    // ----------------------------------------------------------------
    localparam int ORG_ID_W = 24;
    localparam int MODEL_W = 6;
    localparam int REV_W = 4;
    // org id vector bit that holds standard bit 3, and bit 19
    localparam int ORG_HIGH_TOP = 21;
    localparam int ORG_HIGH_BOT = 6;
    localparam int ORG_LOW_TOP = 5;
    localparam int ORG_LOW_BOT = 0;
    // identifier low word field positions
    localparam int ID_LOW_ORG_TOP = 15;
    localparam int ID_LOW_ORG_BOT = 10;
    localparam int ID_LOW_MODEL_TOP = 9;
    localparam int ID_LOW_MODEL_BOT = 4;
    localparam int ID_LOW_REV_TOP = 3;
    localparam int ID_LOW_REV_BOT = 0;

    // arbitrary neutral identity values
    localparam logic [ORG_ID_W-1:0] ORG_ID_DEFAULT = 24'h00_1A2B;
    localparam logic [MODEL_W-1:0] MODEL_DEFAULT = 6'h01;
    localparam logic [REV_W-1:0] REV_DEFAULT = 4'h0;

    // ----------------------------------------------------------------
    // advertisement layout and reset values
    // ----------------------------------------------------------------
    localparam int SEL_W = 5;
    localparam int ADV_NEXT_PAGE_BIT = 15;
    localparam int ADV_ACK_BIT = 14;
    localparam int ADV_FOUR_PAIR_BIT = 9;

    localparam logic RST_REMOTE_FAULT = 1'b0;
    localparam logic [1:0] RST_RESERVED = 2'h0;
    localparam logic RST_FLOW_CTRL = 1'b0;
    localparam logic RST_SPEED_ABILITY = 1'b1;
    localparam logic [SEL_W-1:0] RST_SELECTOR = 5'h01;
    localparam logic FIXED_NEXT_PAGE = 1'b0;
    localparam logic FIXED_FOUR_PAIR = 1'b0;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic next_page_flag;
        logic ack_flag;
        logic remote_fault_flag;
        logic [1:0] reserved;
        logic flow_control_advert;
        logic four_pair_100m_advert;
        logic fast_full_duplex_advert;
        logic fast_half_duplex_advert;
        logic ten_full_duplex_advert;
        logic ten_half_duplex_advert;
        logic [SEL_W-1:0] selector;
    } pia_advert_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } pia_mgmt_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] high;
        logic [DATA_W-1:0] low;
    } pia_ident_t;

endpackage : pia_pkg

`default_nettype wire

// File: src/pia_ident_word.sv
`timescale 1ns/100ps
`default_nettype none

module pia_ident_word #(
    parameter logic [pia_pkg::ORG_ID_W-1:0] ORG_ID = pia_pkg::ORG_ID_DEFAULT,
    parameter logic [pia_pkg::MODEL_W-1:0] MODEL = pia_pkg::MODEL_DEFAULT,
    parameter logic [pia_pkg::REV_W-1:0] REV = pia_pkg::REV_DEFAULT
) (
    // identifier words
    output var pia_pkg::pia_ident_t ident_o
);

    // ----------------------------------------------------------------
    // word assembly, top two org id bits never used
    // ----------------------------------------------------------------
    wire logic [pia_pkg::DATA_W-1:0] high_word;
    wire logic [pia_pkg::DATA_W-1:0] low_word;

    assign high_word = ORG_ID[pia_pkg::ORG_HIGH_TOP:pia_pkg::ORG_HIGH_BOT];
    assign low_word = {ORG_ID[pia_pkg::ORG_LOW_TOP:pia_pkg::ORG_LOW_BOT],
                       MODEL,
                       REV};

    assign ident_o = '{high: high_word, low: low_word};

endmodule : pia_ident_word

`default_nettype wire

// File: src/pia_id_regs.sv
`timescale 1ns/100ps
`default_nettype none

module pia_id_regs #(
    parameter logic [pia_pkg::ORG_ID_W-1:0] ORG_ID = pia_pkg::ORG_ID_DEFAULT,
    parameter logic [pia_pkg::MODEL_W-1:0] MODEL = pia_pkg::MODEL_DEFAULT,
    parameter logic [pia_pkg::REV_W-1:0] REV = pia_pkg::REV_DEFAULT
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // management register port
    input wire pia_pkg::pia_mgmt_req_t mgmt_req_i,
    output logic [pia_pkg::DATA_W-1:0] mgmt_rdata_o,
    output logic mgmt_rvalid_o,
    output logic mgmt_hit_o,
    // auto-negotiation side
    input wire logic autoneg_ack_i,
    output logic [pia_pkg::DATA_W-1:0] advert_word_o,
    output logic advert_updated_o
);

    // ----------------------------------------------------------------
    // identifier words
    // ----------------------------------------------------------------
    pia_pkg::pia_ident_t ident;

    pia_ident_word #(
        .ORG_ID(ORG_ID),
        .MODEL(MODEL),
        .REV(REV)
    ) u_ident (
        .ident_o(ident)
    );

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    wire logic sel_id_high;
    wire logic sel_id_low;
    wire logic sel_advert;
    wire logic sel_any;
    wire logic advert_write;

    assign sel_id_high = (mgmt_req_i.addr == pia_pkg::OFS_ID_HIGH);
    assign sel_id_low = (mgmt_req_i.addr == pia_pkg::OFS_ID_LOW);
    assign sel_advert = (mgmt_req_i.addr == pia_pkg::OFS_ADVERT);
    assign sel_any = sel_id_high | sel_id_low | sel_advert;
    // identifier writes have no target at all
    assign advert_write = mgmt_req_i.wr & sel_advert;

    // ----------------------------------------------------------------
    // advertisement storage
    // ----------------------------------------------------------------
    pia_pkg::pia_advert_t advert_reg;
    pia_pkg::pia_advert_t advert_next;
    pia_pkg::pia_advert_t advert_wr;
    pia_pkg::pia_advert_t advert_rst;
    logic ack_reg;

    assign advert_wr = pia_pkg::pia_advert_t'(mgmt_req_i.wdata);

    assign advert_rst = '{
        next_page_flag: pia_pkg::FIXED_NEXT_PAGE,
        ack_flag: 1'b0,
        remote_fault_flag: pia_pkg::RST_REMOTE_FAULT,
        reserved: pia_pkg::RST_RESERVED,
        flow_control_advert: pia_pkg::RST_FLOW_CTRL,
        four_pair_100m_advert: pia_pkg::FIXED_FOUR_PAIR,
        fast_full_duplex_advert: pia_pkg::RST_SPEED_ABILITY,
        fast_half_duplex_advert: pia_pkg::RST_SPEED_ABILITY,
        ten_full_duplex_advert: pia_pkg::RST_SPEED_ABILITY,
        ten_half_duplex_advert: pia_pkg::RST_SPEED_ABILITY,
        selector: pia_pkg::RST_SELECTOR
    };

    // fixed fields never take write data
    always_comb begin
        advert_next = advert_reg;
        advert_next.next_page_flag = pia_pkg::FIXED_NEXT_PAGE;
        advert_next.ack_flag = 1'b0;
        advert_next.four_pair_100m_advert = pia_pkg::FIXED_FOUR_PAIR;
        if (advert_write) begin
            advert_next.remote_fault_flag = advert_wr.remote_fault_flag;
            advert_next.reserved = advert_wr.reserved;
            advert_next.flow_control_advert = advert_wr.flow_control_advert;
            advert_next.fast_full_duplex_advert = advert_wr.fast_full_duplex_advert;
            advert_next.fast_half_duplex_advert = advert_wr.fast_half_duplex_advert;
            advert_next.ten_full_duplex_advert = advert_wr.ten_full_duplex_advert;
            advert_next.ten_half_duplex_advert = advert_wr.ten_half_duplex_advert;
            advert_next.selector = advert_wr.selector;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            advert_reg <= advert_rst;
        end else begin
            advert_reg <= advert_next;
        end
    end

    // ack follows the negotiation logic only
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= autoneg_ack_i;
        end
    end

    // ----------------------------------------------------------------
    // visible advertisement word
    // ----------------------------------------------------------------
    pia_pkg::pia_advert_t advert_view;

    always_comb begin
        advert_view = advert_reg;
        advert_view.next_page_flag = pia_pkg::FIXED_NEXT_PAGE;
        advert_view.ack_flag = ack_reg;
        advert_view.four_pair_100m_advert = pia_pkg::FIXED_FOUR_PAIR;
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    wire logic [pia_pkg::DATA_W-1:0] rdata_sel;

    assign rdata_sel = sel_id_high ? ident.high :
                       sel_id_low ? ident.low :
                       sel_advert ? pia_pkg::DATA_W'(advert_view) :
                       '0;

    logic [pia_pkg::DATA_W-1:0] rdata_reg;
    logic rvalid_reg;
    logic hit_reg;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rdata_reg <= '0;
            rvalid_reg <= 1'b0;
            hit_reg <= 1'b0;
        end else begin
            rvalid_reg <= mgmt_req_i.rd;
            hit_reg <= mgmt_req_i.rd & sel_any;
            if (mgmt_req_i.rd) begin
                rdata_reg <= rdata_sel;
            end
        end
    end

    assign mgmt_rdata_o = rdata_reg;
    assign mgmt_rvalid_o = rvalid_reg;
    assign mgmt_hit_o = hit_reg;

    // ----------------------------------------------------------------
    // auto-negotiation feed
    // ----------------------------------------------------------------
    logic [pia_pkg::DATA_W-1:0] advert_out_reg;
    logic updated_reg;
    wire logic [pia_pkg::DATA_W-1:0] advert_out_next;

    assign advert_out_next = pia_pkg::DATA_W'(advert_view);

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            advert_out_reg <= pia_pkg::DATA_W'(advert_rst);
            updated_reg <= 1'b0;
        end else begin
            advert_out_reg <= advert_out_next;
            updated_reg <= advert_write;
        end
    end

    assign advert_word_o = advert_out_reg;
    assign advert_updated_o = updated_reg;

endmodule : pia_id_regs

`default_nettype wire

// File: testbench/pia_id_regs_checker.sv
`timescale 1ns/100ps
`default_nettype none
module pia_id_regs_checker #(
    parameter logic [pia_pkg::ORG_ID_W-1:0] ORG_ID = pia_pkg::ORG_ID_DEFAULT,
    parameter logic [pia_pkg::MODEL_W-1:0] MODEL = pia_pkg::MODEL_DEFAULT,
    parameter logic [pia_pkg::REV_W-1:0] REV = pia_pkg::REV_DEFAULT
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // watched ports
    input wire pia_pkg::pia_mgmt_req_t mgmt_req_i,
    input wire logic [pia_pkg::DATA_W-1:0] mgmt_rdata_o,
    input wire logic mgmt_rvalid_o,
    input wire logic mgmt_hit_o,
    input wire logic autoneg_ack_i,
    input wire logic [pia_pkg::DATA_W-1:0] advert_word_o,
    input wire logic advert_updated_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    wire logic [4:0] req_addr = mgmt_req_i.addr;
    wire logic mapped = req_addr inside {[5'h02:5'h04]};
    sequence s_rd(ofs); mgmt_req_i.rd && req_addr == ofs; endsequence
    sequence s_wr_adv; mgmt_req_i.wr && req_addr == pia_pkg::OFS_ADVERT; endsequence
    id_high_a: assert property (
        s_rd(pia_pkg::OFS_ID_HIGH) |=> mgmt_hit_o && mgmt_rdata_o == ORG_ID[21:6])
        else $error("id high word wrong");
    id_low_a: assert property (
        s_rd(pia_pkg::OFS_ID_LOW) |=> mgmt_rdata_o == {ORG_ID[5:0], MODEL, REV})
        else $error("id low word wrong");
    unmapped_read_a: assert property (
        mgmt_req_i.rd && !mapped |=> mgmt_rvalid_o && !mgmt_hit_o && mgmt_rdata_o == 16'h0000)
        else $error("unmapped read answered wrongly");
    fixed_bits_a: assert property (
        !advert_word_o[15] && !advert_word_o[9]) else $error("fixed advert bit set");
    advert_load_a: assert property (
        s_wr_adv |-> ##2 (advert_word_o & 16'h3DFF) == ($past(mgmt_req_i.wdata, 2) & 16'h3DFF))
        else $error("advert word not loaded");
    ack_path_a: assert property (
        !$past(rst_i) && !$past(rst_i, 2) |-> advert_word_o[14] == $past(autoneg_ack_i, 2))
        else $error("ack bit not following");
    update_pulse_a: assert property (
        s_wr_adv |=> advert_updated_o) else $error("update pulse missing");
    rvalid_cause_a: assert property (
        $rose(mgmt_rvalid_o) |-> $past(mgmt_req_i.rd)) else $error("stray read answer");
    rdata_hold_a: assert property (
        !$past(mgmt_req_i.rd) && !$past(rst_i) |-> $stable(mgmt_rdata_o))
        else $error("read data moved");
endmodule : pia_id_regs_checker
`default_nettype wire

// File: testbench/pia_mgmt_station.sv
`timescale 1ns/100ps
`default_nettype none
module pia_mgmt_station (
    // clock
    input wire logic clk_sys_i,
    // request side
    output var pia_pkg::pia_mgmt_req_t req_o,
    // answer side
    input wire logic [15:0] rdata_i,
    input wire logic rvalid_i,
    input wire logic hit_i
);
    initial req_o = '0;
    // one access; raw lets the ack bit through on purpose
    task automatic xfer(input logic wr, input logic rd, input logic [4:0] addr,
            input logic [15:0] wdata, input logic raw, output logic [15:0] got,
            output logic [1:0] vh);
        @(posedge clk_sys_i);
        req_o <= '{wr, rd, addr, wdata & (raw ? 16'hE7FF : 16'hA7FF)};
        @(posedge clk_sys_i);
        // idle bus shows no stale address or data
        req_o <= '{1'b0, 1'b0, ~addr, ~wdata};
        #1;
        got = rdata_i;
        vh = {rvalid_i, hit_i};
    endtask : xfer
endmodule : pia_mgmt_station
`default_nettype wire

// File: testbench/pia_id_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module pia_id_regs_tb;
    // arbitrary identity values
    localparam logic [23:0] ORG_ID = 24'h5A_C3E1;
    localparam logic [5:0] MODEL = 6'h2D;
    localparam logic [3:0] REV = 4'h9;
    localparam logic [15:0] ID_HIGH = ORG_ID[21:6];
    localparam logic [15:0] ID_LOW = {ORG_ID[5:0], MODEL, REV};
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic autoneg_ack_i = 1'b0;
    pia_pkg::pia_mgmt_req_t req;
    logic [15:0] rdata, adv, got, d, shadow;
    logic rvalid, hit, upd;
    logic [1:0] vh;
    logic [4:0] a;
    int fail_count = 0;
    int cmp_count = 0;
    pia_id_regs #(.ORG_ID(ORG_ID), .MODEL(MODEL), .REV(REV)) DUT (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .mgmt_req_i(req), .mgmt_rdata_o(rdata), .mgmt_rvalid_o(rvalid),
        .mgmt_hit_o(hit), .autoneg_ack_i(autoneg_ack_i), .advert_word_o(adv),
        .advert_updated_o(upd));
    pia_mgmt_station stn (.clk_sys_i(clk_sys_i), .req_o(req), .rdata_i(rdata),
        .rvalid_i(rvalid), .hit_i(hit));
    initial forever #20 clk_sys_i = ~clk_sys_i;
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    function automatic logic [15:0] exp_adv(input logic [15:0] w, input logic ack);
        return (w & 16'h25FF) | {1'b0, ack, 14'h0000};
    endfunction : exp_adv
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results
    initial begin
        d = 16'($urandom(44));
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        stn.xfer(1'b0, 1'b1, 5'h02, 16'h0000, 1'b0, got, vh);
        chk(got, ID_HIGH);
        chk({14'h0000, vh}, 16'h0003);
        stn.xfer(1'b0, 1'b1, 5'h03, 16'h0000, 1'b0, got, vh);
        chk(got, ID_LOW);
        stn.xfer(1'b0, 1'b1, 5'h04, 16'h0000, 1'b0, got, vh);
        chk(got, 16'h01E1);
        $display("test reset values done");
        for (int i = 0; i < 40; i++) begin
            d = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($urandom);
            @(posedge clk_sys_i);
            autoneg_ack_i <= 1'($urandom_range(1));
            stn.xfer(1'b1, 1'b0, pia_pkg::OFS_ADVERT, d, i[0], got, vh);
            chk({15'h0000, upd}, 16'h0001);
            @(posedge clk_sys_i);
            #1 chk(adv, exp_adv(d, autoneg_ack_i));
            stn.xfer(1'b0, 1'b1, pia_pkg::OFS_ADVERT, 16'h0000, 1'b0, got, vh);
            chk(got, exp_adv(d, autoneg_ack_i));
            chk({14'h0000, vh}, 16'h0003);
        end
        shadow = exp_adv(d, autoneg_ack_i);
        $display("test advert writes done");
        for (int i = 0; i < 10; i++) begin
            a = (i < 2) ? 5'(i + 2) : 5'(5 + $urandom_range(26));
            stn.xfer(1'b1, 1'b0, a, 16'($urandom), 1'b1, got, vh);
            stn.xfer(1'b0, 1'b1, a, 16'h0000, 1'b0, got, vh);
            chk(got, (a == 5'h02) ? ID_HIGH : (a == 5'h03) ? ID_LOW : 16'h0000);
            chk({14'h0000, vh}, (a < 5'h04) ? 16'h0003 : 16'h0002);
        end
        $display("test read-only and unmapped done");
        stn.xfer(1'b1, 1'b1, pia_pkg::OFS_ADVERT, 16'h0000, 1'b0, got, vh);
        chk(got, shadow);
        stn.xfer(1'b0, 1'b1, pia_pkg::OFS_ADVERT, 16'h0000, 1'b0, got, vh);
        chk(got, exp_adv(16'h0000, autoneg_ack_i));
        $display("test read with write done");
        results();
    end
endmodule : pia_id_regs_tb
bind pia_id_regs pia_id_regs_checker #(.ORG_ID(ORG_ID), .MODEL(MODEL), .REV(REV)) chk_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .mgmt_req_i(mgmt_req_i),
    .mgmt_rdata_o(mgmt_rdata_o), .mgmt_rvalid_o(mgmt_rvalid_o), .mgmt_hit_o(mgmt_hit_o),
    .autoneg_ack_i(autoneg_ack_i), .advert_word_o(advert_word_o),
    .advert_updated_o(advert_updated_o));
`default_nettype wire
